// >>> sequencer_pkg.sv
// Summary of operation
// - interrupt low pulse lasts 10 to 250 us
// - shutdown request held 150 us is recognised
// - shutdown request ignored during turn-on blanking
// - shutdown request low at blanking end: disable
// - wait 400 ms after power-down starts, then disable
// - 400 ms lockout between disable and enable
// - first valid on command releases converter enable
// - disable at power-down end or on shutdown
// - mode A high: shutdown also stops diodes
// - interrupt 26 ms into off press, held
// - mode A low: mode B gates primary diode
// - mode A high: mode B edges on/off
// - off debounce is 26 ms plus extension
// - on debounce is 26 ms plus extension
// - disabled diode driver forced to off
// - primary switch off drives status low
// - release then 26 ms press asserts interrupt
// - press held full off debounce starts power-down
// - extend edge restarts the 400 ms wait
// - on debounce press releases converter enable
package sequencer_pkg;

  localparam int CLOCK_PERIOD_NS = 100;
  localparam int TICK_NS         = 10000;
  localparam int TICK_CYCLES     = TICK_NS / CLOCK_PERIOD_NS;
  localparam int DEBOUNCE_MS     = 26;
  localparam int EXT_STEP_MS     = 1;
  localparam int BLANK_MS        = 400;
  localparam int OFF_WAIT_MS     = 400;
  localparam int LOCKOUT_MS      = 400;
  localparam int KILL_MIN_US     = 150;
  localparam int INT_PULSE_US    = 50;
  localparam int INT_MIN_US      = 10;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] DEBOUNCE_TICKS_DEF =
    CNT_W'(DEBOUNCE_MS * 1000000 / TICK_NS);
  localparam logic [CNT_W-1:0] EXT_STEP_TICKS_DEF =
    CNT_W'(EXT_STEP_MS * 1000000 / TICK_NS);
  localparam logic [CNT_W-1:0] BLANK_TICKS_DEF =
    CNT_W'(BLANK_MS * 1000000 / TICK_NS);
  localparam logic [CNT_W-1:0] OFF_WAIT_TICKS_DEF =
    CNT_W'(OFF_WAIT_MS * 1000000 / TICK_NS);
  localparam logic [CNT_W-1:0] LOCKOUT_TICKS_DEF =
    CNT_W'(LOCKOUT_MS * 1000000 / TICK_NS);
  localparam logic [CNT_W-1:0] KILL_TICKS =
    CNT_W'((KILL_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
  localparam logic [CNT_W-1:0] INT_PULSE_TICKS =
    CNT_W'(INT_PULSE_US * 1000 / TICK_NS);
  localparam int INT_MIN_CYCLES = (INT_MIN_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] ON_EXT_RST  = 8'h00;
  localparam logic [7:0] OFF_EXT_RST = 8'h00;
  localparam int ON_EXT_POS  = 0;
  localparam int OFF_EXT_POS = 8;

  // pin order: extend, mode B, mode A, shutdown request, button
  localparam int PIN_W = 5;
  localparam logic [PIN_W-1:0] PIN_RST = 5'h03;

  typedef enum logic [2:0] {
    S_OFF    = 3'b000,
    S_ON_DB  = 3'b001,
    S_BLANK  = 3'b010,
    S_RUN    = 3'b011,
    S_OFF_DB = 3'b100,
    S_WAIT   = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic [7:0] offExt;
    logic [7:0] onExt;
  } ctrl_t;

  typedef struct packed {
    logic       primaryOn;
    logic       secondaryOn;
    logic       lockoutBusy;
    logic       intActive;
    logic       enReleased;
    seq_state_t state;
  } status_t;

endpackage

// >>> input_sync.sv
`timescale 1ns/1ps
module input_sync
  import sequencer_pkg::*;
#(
  parameter int             W         = 1,
  parameter logic [W-1:0]   RESET_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit moves only once the last two stages agree
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= RESET_VAL;
    end else begin
      q <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
  end
endmodule // input_sync

// >>> pushbutton_power_sequencer.sv
`timescale 1ns/1ps
module pushbutton_power_sequencer
  import sequencer_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEBOUNCE_TICKS = DEBOUNCE_TICKS_DEF,
  parameter logic [CNT_W-1:0] EXT_STEP_TICKS = EXT_STEP_TICKS_DEF,
  parameter logic [CNT_W-1:0] BLANK_TICKS    = BLANK_TICKS_DEF,
  parameter logic [CNT_W-1:0] OFF_WAIT_TICKS = OFF_WAIT_TICKS_DEF,
  parameter logic [CNT_W-1:0] LOCKOUT_TICKS  = LOCKOUT_TICKS_DEF
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic [DATA_W-1:0] writeData,
  input  wire logic              writeStrobe,
  input  wire logic              readStrobe,
  output logic      [DATA_W-1:0] readData,
  input  wire logic              buttonInN,
  input  wire logic              shutdownReqN,
  input  wire logic              modeSelectA,
  input  wire logic              modeSelectB,
  input  wire logic              activityExtendIn,
  output logic                   converterEnableOut,
  output logic                   converterEnableOe,
  output logic                   interruptOut,
  output logic                   interruptOe,
  output logic                   primaryGateDrive,
  output logic                   secondaryGateDrive,
  output logic                   primaryPathOffFlagN,
  output logic                   primaryPathOffOe
);

  logic [PIN_W-1:0] pins;
  logic             btnN;
  logic             killN;
  logic             modeA;
  logic             modeB;
  logic             extend;

  input_sync #(
    .W         (PIN_W),
    .RESET_VAL (PIN_RST)
  ) u_sync (
    .clock (clock),
    .reset (reset),
    .d     ({activityExtendIn, modeSelectB, modeSelectA, shutdownReqN, buttonInN}),
    .q     (pins)
  );

  assign {extend, modeB, modeA, killN, btnN} = pins;

  // previous levels for edge detection
  logic btnN_r;
  logic modeB_r;
  logic extend_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      btnN_r   <= 1'b1;
      modeB_r  <= 1'b0;
      extend_r <= 1'b0;
    end else begin
      btnN_r   <= btnN;
      modeB_r  <= modeB;
      extend_r <= extend;
    end
  end

  logic btnFall;
  logic onCmd;
  logic offCmd;
  logic extEdge;
  logic pbAllowed;

  assign btnFall   = btnN_r & ~btnN;
  assign onCmd     = modeA & modeB & ~modeB_r;
  assign offCmd    = modeA & ~modeB & modeB_r;
  assign extEdge   = extend ^ extend_r;
  // with mode A high the button acts only while mode B is high
  assign pbAllowed = ~modeA | modeB;

  // one shared timebase for every interval
  logic [7:0] tickDiv_r;
  logic       tick;

  assign tick = (tickDiv_r == 8'(TICK_CYCLES - 1));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tickDiv_r <= 8'h00;
    end else if (tick) begin
      tickDiv_r <= 8'h00;
    end else begin
      tickDiv_r <= tickDiv_r + 8'h01;
    end
  end

  // registers
  ctrl_t   ctrl_r;
  status_t status;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r.onExt  <= ON_EXT_RST;
      ctrl_r.offExt <= OFF_EXT_RST;
    end else if (writeStrobe && address == CTRL_ADDR) begin
      ctrl_r.onExt  <= writeData[ON_EXT_POS +: 8];
      ctrl_r.offExt <= writeData[OFF_EXT_POS +: 8];
    end
  end

  // shutdown request must stay low for a filter span before it counts
  logic [CNT_W-1:0] killLow_r;
  logic             killTrip;

  assign killTrip = (killLow_r == KILL_TICKS);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      killLow_r <= '0;
    end else if (killN) begin
      killLow_r <= '0;
    end else if (tick && !killTrip) begin
      killLow_r <= killLow_r + CNT_W'(1);
    end
  end

  // sequencer
  seq_state_t       state_r;
  seq_state_t       state_nxt;
  logic [CNT_W-1:0] timer_r;
  logic [CNT_W-1:0] lockout_r;
  logic [CNT_W-1:0] onTarget;
  logic [CNT_W-1:0] offTarget;
  logic             timerRestart;

  // extension counts one step per unit on top of the fixed debounce
  assign onTarget  = DEBOUNCE_TICKS + CNT_W'(ctrl_r.onExt) * EXT_STEP_TICKS;
  assign offTarget = DEBOUNCE_TICKS + CNT_W'(ctrl_r.offExt) * EXT_STEP_TICKS;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_OFF: begin
        if (lockout_r == '0) begin
          if (onCmd) begin
            state_nxt = S_BLANK;
          end else if (pbAllowed && !btnN) begin
            state_nxt = S_ON_DB;
          end
        end
      end
      S_ON_DB: begin
        if (btnN || !pbAllowed) begin
          state_nxt = S_OFF;
        end else if (timer_r >= onTarget) begin
          state_nxt = S_BLANK;
        end
      end
      S_BLANK: begin
        // shutdown request is not looked at until blanking ends
        if (timer_r >= BLANK_TICKS) begin
          state_nxt = killN ? S_RUN : S_OFF;
        end
      end
      S_RUN: begin
        if (killTrip) begin
          state_nxt = S_OFF;
        end else if (offCmd) begin
          state_nxt = S_WAIT;
        end else if (pbAllowed && btnFall) begin
          state_nxt = S_OFF_DB;
        end
      end
      S_OFF_DB: begin
        if (killTrip) begin
          state_nxt = S_OFF;
        end else if (offCmd) begin
          state_nxt = S_WAIT;
        end else if (btnN || !pbAllowed) begin
          state_nxt = S_RUN;
        end else if (timer_r >= offTarget) begin
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (killTrip || timer_r >= OFF_WAIT_TICKS) begin
          state_nxt = S_OFF;
        end
      end
      default: begin
        state_nxt = S_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= S_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // an extend edge during the wait starts the wait over
  assign timerRestart = (state_nxt != state_r) || (state_r == S_WAIT && extEdge);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer_r <= '0;
    end else if (timerRestart) begin
      timer_r <= '0;
    end else if (tick && timer_r != '1) begin
      timer_r <= timer_r + CNT_W'(1);
    end
  end

  logic enDrive_nxt;

  assign enDrive_nxt = (state_nxt == S_OFF) || (state_nxt == S_ON_DB);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      converterEnableOe <= 1'b1;
    end else begin
      converterEnableOe <= enDrive_nxt;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lockout_r <= '0;
    end else if (enDrive_nxt && !converterEnableOe) begin
      lockout_r <= LOCKOUT_TICKS;
    end else if (tick && lockout_r != '0) begin
      lockout_r <= lockout_r - CNT_W'(1);
    end
  end

  // interrupt: held while requested, and never shorter than one pulse span
  logic             intReq;
  logic [CNT_W-1:0] intHold_r;

  // entering the wait raises the interrupt together with the state, not a cycle late
  assign intReq = (state_nxt == S_WAIT) ||
                  (state_r == S_OFF_DB && timer_r >= DEBOUNCE_TICKS);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      interruptOe <= 1'b0;
    end else if (intReq) begin
      interruptOe <= 1'b1;
    end else if (intHold_r == '0) begin
      interruptOe <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      intHold_r <= '0;
    end else if (intReq && !interruptOe) begin
      intHold_r <= INT_PULSE_TICKS;
    end else if (tick && intHold_r != '0) begin
      intHold_r <= intHold_r - CNT_W'(1);
    end
  end

  // ideal diode enables
  logic sysOn;
  logic primOn_nxt;
  logic secOn_nxt;
  logic killCut;

  assign sysOn = !enDrive_nxt;
  // the shutdown request is blind during blanking, for the diodes too
  assign killCut = killTrip && (state_r != S_BLANK);

  always_comb begin
    if (modeA) begin
      primOn_nxt = sysOn && !killCut;
      secOn_nxt  = sysOn && !killCut;
    end else begin
      primOn_nxt = !modeB;
      secOn_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      primaryGateDrive   <= 1'b0;
      secondaryGateDrive <= 1'b0;
      primaryPathOffOe   <= 1'b1;
    end else begin
      primaryGateDrive   <= primOn_nxt;
      secondaryGateDrive <= secOn_nxt;
      primaryPathOffOe   <= !primOn_nxt;
    end
  end

  assign converterEnableOut  = 1'b0;
  assign interruptOut        = 1'b0;
  assign primaryPathOffFlagN = 1'b0;

  always_comb begin
    status.primaryOn   = primaryGateDrive;
    status.secondaryOn = secondaryGateDrive;
    status.lockoutBusy = (lockout_r != '0);
    status.intActive   = interruptOe;
    status.enReleased  = !converterEnableOe;
    status.state       = state_r;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readData <= '0;
    end else if (readStrobe && address == CTRL_ADDR) begin
      readData <= DATA_W'(ctrl_r);
    end else if (readStrobe && address == STATUS_ADDR) begin
      readData <= DATA_W'(status);
    end else begin
      readData <= '0;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic [15:0] intLen_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      intLen_r <= '0;
    end else if (interruptOe) begin
      intLen_r <= (intLen_r == '1) ? intLen_r : intLen_r + 16'h0001;
    end else begin
      intLen_r <= '0;
    end
  end

  int_width_a: assert property ($fell(interruptOe) |-> $past(intLen_r) >= 16'(INT_MIN_CYCLES))
    else $error("interrupt pulse too short");
  kill_trip_a: assert property ((state_r == S_RUN && killTrip) |=> converterEnableOe && state_r == S_OFF)
    else $error("shutdown request not honoured");
  blank_hold_a: assert property ((state_r == S_BLANK && timer_r < BLANK_TICKS) |=> !converterEnableOe)
    else $error("enable dropped during blanking");
  blank_end_a: assert property ((state_r == S_BLANK && timer_r >= BLANK_TICKS && !killN) |=> converterEnableOe)
    else $error("enable kept after failed blanking");
  wait_end_a: assert property ((state_r == S_WAIT && timer_r >= OFF_WAIT_TICKS) |=> converterEnableOe)
    else $error("wait end did not disable");
  lockout_a: assert property ($fell(converterEnableOe) |-> $past(lockout_r) == '0)
    else $error("enable released inside lockout");
  int_held_a: assert property (state_r == S_WAIT |-> interruptOe)
    else $error("interrupt not held in power-down");
  gate_mode_a: assert property ((!reset && !modeA) |=> primaryGateDrive == !$past(modeB) && secondaryGateDrive)
    else $error("primary gate ignores mode B");
  status_flag_a: assert property (primaryPathOffOe == !primaryGateDrive)
    else $error("status flag disagrees with gate");
  ext_restart_a: assert property ((state_r == S_WAIT && state_nxt == S_WAIT && extEdge) |=> timer_r == '0)
    else $error("extend edge did not restart wait");

  turn_on_c: cover property (state_r == S_BLANK ##1 state_r == S_RUN);
  power_down_c: cover property (state_r == S_WAIT ##1 state_r == S_OFF);
  extend_c: cover property (state_r == S_WAIT && extEdge);
  kill_c: cover property (state_r == S_RUN && killTrip);

endmodule // pushbutton_power_sequencer

// >>> host_system_model.sv
`timescale 1ns/1ps
module host_system_model (
  input  wire logic       clock,
  input  wire logic       enWire,
  input  wire logic       intWire,
  input  wire logic       killCmd,
  input  wire logic       slowStart,
  input  wire logic [3:0] extendCount,
  output logic            shutdownReqN,
  output logic            activityExtendIn
);
  localparam logic [15:0] EXT_GAP = 16'h05DC;

  logic [15:0] upCnt;
  logic [15:0] gapCnt;
  logic [3:0]  edgesLeft;
  logic        intPrev;

  initial begin
    upCnt = '0;
    gapCnt = '0;
    edgesLeft = '0;
    intPrev = 1'b1;
    activityExtendIn = 1'b0;
  end

  // power good only once the converter runs; a slow start outlasts the blanking
  assign shutdownReqN = enWire && !killCmd && (upCnt > (slowStart ? 16'h1000 : 16'h0010));

  always @(posedge clock) begin
    if (!enWire) upCnt <= '0;
    else if (upCnt != 16'hFFFF) upCnt <= upCnt + 16'h0001;
  end

  // housekeeping edges come well inside each wait, so every one restarts it
  always @(posedge clock) begin
    intPrev <= intWire;
    if (intPrev && !intWire) begin
      edgesLeft <= extendCount;
      gapCnt <= EXT_GAP;
    end else if (edgesLeft != 4'h0) begin
      if (gapCnt == 16'h0000) begin
        activityExtendIn <= !activityExtendIn;
        edgesLeft <= edgesLeft - 4'h1;
        gapCnt <= EXT_GAP;
      end else begin
        gapCnt <= gapCnt - 16'h0001;
      end
    end
  end
endmodule // host_system_model

// >>> pushbutton_power_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module pushbutton_power_sequencer_tb_top;
  import sequencer_pkg::*;
  localparam logic [CNT_W-1:0] DB = 16'h0014;
  localparam logic [CNT_W-1:0] ES = 16'h0002;
  localparam logic [CNT_W-1:0] LW = 16'h001E;

  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic [DATA_W-1:0] writeData = '0;
  logic              writeStrobe = 1'b0;
  logic              readStrobe = 1'b0;
  logic [DATA_W-1:0] readData;
  logic              buttonInN = 1'b1;
  logic              shutdownReqN;
  logic              modeSelectA = 1'b0;
  logic              modeSelectB = 1'b0;
  logic              activityExtendIn;
  logic              converterEnableOe;
  logic              interruptOe;
  logic              primaryGateDrive;
  logic              secondaryGateDrive;
  logic              primaryPathOffOe;
  logic [2:0]        odLevel;
  logic              killCmd = 1'b0;
  logic              slowStart = 1'b0;
  logic [3:0]        extendCount = '0;
  logic [DATA_W-1:0] rd;
  logic              ok;
  int                n;
  int                error_cnt = 0;
  int                n_tests = 0;

  always #50 clock = ~clock;

  pushbutton_power_sequencer #(.DEBOUNCE_TICKS(DB), .EXT_STEP_TICKS(ES), .BLANK_TICKS(LW),
    .OFF_WAIT_TICKS(LW), .LOCKOUT_TICKS(LW)) dut (
    .clock, .reset, .address, .writeData, .writeStrobe, .readStrobe, .readData,
    .buttonInN, .shutdownReqN, .modeSelectA, .modeSelectB, .activityExtendIn,
    .converterEnableOut(odLevel[2]), .converterEnableOe, .interruptOut(odLevel[1]), .interruptOe,
    .primaryGateDrive, .secondaryGateDrive, .primaryPathOffFlagN(odLevel[0]), .primaryPathOffOe);

  // open-drain lines idle high through their pull-ups
  host_system_model host (.clock, .enWire(!converterEnableOe), .intWire(!interruptOe),
    .killCmd, .slowStart, .extendCount, .shutdownReqN, .activityExtendIn);

  // counts are in cycles and targets in ticks; one tick early to two ticks late is allowed
  function automatic logic inwin(int c, int t);
    return (c >= t * 100 - 100) && (c <= t * 100 + 200);
  endfunction

  function automatic logic pick(int w);
    return (w == 0) ? converterEnableOe : interruptOe;
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic waitsig(input int w, input logic v, input int lim, output int c);
    c = 0;
    while (pick(w) !== v) begin
      @(negedge clock);
      c++;
      if (c >= lim) begin
        error_cnt++;
        $display("mismatch wait%0d exp %0b got timeout", w, v);
        final_report();
      end
    end
  endtask

  task automatic stay(input int w, input logic v, input int cyc, output logic good);
    good = 1'b1;
    repeat (cyc) begin
      @(negedge clock);
      if (pick(w) !== v) good = 1'b0;
    end
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= wr;
    readStrobe <= !wr;
    @(posedge clock);
    writeStrobe <= 1'b0;
    readStrobe <= 1'b0;
    @(negedge clock);
    rd = readData;
  endtask

  task automatic press_on();
    @(posedge clock) buttonInN <= 1'b0;
    waitsig(0, 1'b0, 4000, n);
    @(posedge clock) buttonInN <= 1'b1;
  endtask

  task automatic regs_test();
    bus(1'b1, CTRL_ADDR, 32'h0000_0203);
    bus(1'b0, CTRL_ADDR, '0);
    `CHK("ctrl", 16'h0203, rd[15:0])
    bus(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
    bus(1'b0, STATUS_ADDR, '0);
    `CHK("statusReleased", 1'b0, rd[3])
    bus(1'b0, 8'h08, '0);
    `CHK("unmapped", 32'h0000_0000, rd)
  endtask

  task automatic mode_low_test();
    @(posedge clock) modeSelectB <= 1'b1;
    repeat (10) @(negedge clock);
    `CHK("modeBHigh", 3'b011, {primaryGateDrive, secondaryGateDrive, primaryPathOffOe})
    @(posedge clock) modeSelectB <= 1'b0;
    repeat (10) @(negedge clock);
    `CHK("modeBLow", 3'b110, {primaryGateDrive, secondaryGateDrive, primaryPathOffOe})
  endtask

  task automatic on_test();
    @(posedge clock) buttonInN <= 1'b0;
    waitsig(0, 1'b0, 4000, n);
    `CHK("onTime", 1'b1, inwin(n, 26))
    `CHK("intQuiet", 1'b0, interruptOe)
    @(posedge clock) buttonInN <= 1'b1;
    repeat (300) @(posedge clock);
    killCmd <= 1'b1;
    repeat (2400) @(posedge clock);
    killCmd <= 1'b0;
    stay(0, 1'b0, 2000, ok);
    `CHK("blanking", 1'b1, ok)
  endtask

  task automatic off_test();
    @(posedge clock) buttonInN <= 1'b0;
    waitsig(1, 1'b1, 4000, n);
    `CHK("intDelay", 1'b1, inwin(n, 20))
    @(posedge clock) buttonInN <= 1'b1;
    waitsig(1, 1'b0, 4000, n);
    `CHK("intPulse", 1'b1, n >= INT_MIN_CYCLES && n <= 2500)
    `CHK("stillOn", 1'b0, converterEnableOe)
    repeat (200) @(posedge clock);
    buttonInN <= 1'b0;
    waitsig(1, 1'b1, 4000, n);
    stay(1, 1'b1, 600, ok);
    `CHK("intHeld", 1'b1, ok)
    @(posedge clock) buttonInN <= 1'b1;
    waitsig(0, 1'b1, 4000, n);
    `CHK("offWait", 1'b1, inwin(n + 600, 34))
    @(posedge clock) buttonInN <= 1'b0;
    stay(0, 1'b1, 2800, ok);
    `CHK("lockout", 1'b1, ok)
    @(posedge clock) buttonInN <= 1'b1;
    repeat (400) @(posedge clock);
  endtask

  task automatic kill_test();
    press_on();
    repeat (3200) @(posedge clock);
    killCmd <= 1'b1;
    waitsig(0, 1'b1, 5000, n);
    `CHK("killTime", 1'b1, inwin(n, 15))
    repeat (5000 - n) @(posedge clock);
    killCmd <= 1'b0;
    slowStart <= 1'b1;
    press_on();
    waitsig(0, 1'b1, 4000, n);
    `CHK("blankEnd", 1'b1, inwin(n, 30))
    slowStart <= 1'b0;
    repeat (3200) @(posedge clock);
  endtask

  task automatic mode_high_test();
    modeSelectA <= 1'b1;
    @(posedge clock) modeSelectB <= 1'b1;
    waitsig(0, 1'b0, 300, n);
    repeat (5) @(negedge clock);
    `CHK("gatesOn", 2'b11, {primaryGateDrive, secondaryGateDrive})
    repeat (3200) @(posedge clock);
    killCmd <= 1'b1;
    waitsig(0, 1'b1, 5000, n);
    repeat (5) @(negedge clock);
    `CHK("killGates", 3'b001, {primaryGateDrive, secondaryGateDrive, primaryPathOffOe})
    repeat (5000 - n) @(posedge clock);
    killCmd <= 1'b0;
    modeSelectB <= 1'b0;
    repeat (10) @(posedge clock);
    extendCount <= 4'h1;
    modeSelectB <= 1'b1;
    waitsig(0, 1'b0, 300, n);
    repeat (3200) @(posedge clock);
    modeSelectB <= 1'b0;
    repeat (20) @(negedge clock);
    `CHK("digOffInt", 1'b1, interruptOe)
    waitsig(0, 1'b1, 6000, n);
    `CHK("extendWait", 1'b1, inwin(n + 20, 45))
  endtask

  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    `CHK("enReset", 1'b1, converterEnableOe)
    `CHK("intReset", 1'b0, interruptOe)
    `CHK("odLevel", 3'b000, odLevel)
    regs_test();
    mode_low_test();
    on_test();
    off_test();
    kill_test();
    mode_high_test();
    final_report();
  end
endmodule // pushbutton_power_sequencer_tb_top
